//--- src/mss_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - start mode 0 direct, 1 tracking, 2 excite
// - direct, zero brake time: start at start frequency
// - direct, nonzero brake time: brake, then start
// - tracking finds speed, direction, starts there
// - excite only asynchronous; zero time skips it
// - tracking start: loss, mains or maximum frequency
// - tracking rate default 20, larger is faster
// - hold start frequency for hold time first
// - target below start frequency at start: standby, zero output
// - direction reversal skips start frequency hold
// - hold excluded from acceleration, flagged for sequencer
// - jump to start frequency, hold, then ramp to target
// - brake only in direct mode, current scales force
// - excite at set current for set time
// - current base is motor or 80% drive rating
// - ramp mode 0 linear, 1 static, 2 dynamic
// - four acceleration sets chosen by input terminals
// - static shapes fixed target; dynamic tracks changes
// - dynamic falls back linear beyond 100s or 6x
// - S-curve start and end proportions, default 30%
module mss_sequencer
   import mss_pkg::*;
#(
   parameter int MS_CYC_P = MS_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [8:0]  multi_function_inputs,
   input  wire logic        track_match,
   input  wire logic        track_dir,
   output mss_drive_t       drive
);

   // ****************************************************************
   // Avalon slave
   // ****************************************************************
   logic              ack_r;
   logic              wr_en;
   logic [31:0]       readdata_r;
   logic [31:0]       rd_mux;
   logic [2:0]        ctrl_r;
   logic [5:0]        mode_r;
   logic [6:0]        trate_r;
   logic [15:0]       sfreq_r;
   logic [15:0]       hold_r;
   logic [6:0]        bcur_r;
   logic [15:0]       btime_r;
   logic [15:0]       sst_r;
   logic [15:0]       send_r;
   logic [15:0]       tgt_r;
   logic [15:0]       acc_r [4];
   logic [15:0]       dec_r [4];
   logic [15:0]       maxf_r;
   logic [15:0]       mains_r;
   logic [15:0]       rated_r;
   logic [15:0]       lossf_r;
   logic [15:0]       motor_a_r;
   logic [15:0]       drive_a_r;
   mss_state_t        state_r;
   mss_state_t        state_nxt;
   logic [15:0]       freq_r;
   logic [15:0]       dc_amp;
   mss_drive_t        drive_r;

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_en           = avs_write & ack_r;
   assign avs_readdata    = readdata_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      case (avs_address)
         OFS_CTRL:   rd_mux = {29'h0, ctrl_r};
         OFS_MODE:   rd_mux = {26'h0, mode_r};
         OFS_TRATE:  rd_mux = {25'h0, trate_r};
         OFS_SFREQ:  rd_mux = {16'h0, sfreq_r};
         OFS_HOLD:   rd_mux = {16'h0, hold_r};
         OFS_BCUR:   rd_mux = {25'h0, bcur_r};
         OFS_BTIME:  rd_mux = {16'h0, btime_r};
         OFS_SCURVE: rd_mux = {send_r, sst_r};
         OFS_TARGET: rd_mux = {16'h0, tgt_r};
         OFS_FLIM:   rd_mux = {mains_r, maxf_r};
         OFS_MOTOR:  rd_mux = {lossf_r, rated_r};
         OFS_AMPS:   rd_mux = {drive_a_r, motor_a_r};
         OFS_STATUS: rd_mux = {freq_r, 9'h0, state_r};
         OFS_OUTCUR: rd_mux = {16'h0, drive_r.cur};
         default: begin
            if (avs_address >= OFS_ACC0 && avs_address < OFS_FLIM && avs_address[1:0] == 2'h0) begin
               rd_mux = {dec_r[avs_address[3:2] + 2'h3], acc_r[avs_address[3:2] + 2'h3]};
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata_r <= 32'h0;
      end else if (avs_read && !ack_r) begin
         readdata_r <= rd_mux;
      end
   end

   // Settings start from their defaults after reset.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r    <= 3'h0;
         mode_r    <= 6'h0;
         trate_r   <= RST_TRATE;
         sfreq_r   <= RST_SFREQ;
         hold_r    <= RST_HOLD;
         bcur_r    <= RST_BCUR;
         btime_r   <= RST_BTIME;
         sst_r     <= RST_SRATIO;
         send_r    <= RST_SRATIO;
         tgt_r     <= 16'h0;
         maxf_r    <= RST_FREQ;
         mains_r   <= RST_FREQ;
         rated_r   <= RST_FREQ;
         lossf_r   <= 16'h0;
         motor_a_r <= RST_AMPS;
         drive_a_r <= RST_AMPS;
         for (int i = 0; i < 4; i++) begin
            acc_r[i] <= RST_ACC;
            dec_r[i] <= RST_ACC;
         end
      end else if (wr_en) begin
         case (avs_address)
            OFS_CTRL:   ctrl_r <= avs_writedata[2:0];
            OFS_MODE:   mode_r <= avs_writedata[5:0];
            OFS_TRATE:  trate_r <= avs_writedata[6:0];
            OFS_SFREQ:  sfreq_r <= avs_writedata[15:0];
            OFS_HOLD:   hold_r <= avs_writedata[15:0];
            OFS_BCUR:   bcur_r <= avs_writedata[6:0];
            OFS_BTIME:  btime_r <= avs_writedata[15:0];
            OFS_TARGET: tgt_r <= avs_writedata[15:0];
            OFS_SCURVE: begin
               // Start and end proportions together may not pass 100.0%.
               if (32'(avs_writedata[15:0]) + 32'(avs_writedata[31:16]) <= PERMILLE) begin
                  sst_r  <= avs_writedata[15:0];
                  send_r <= avs_writedata[31:16];
               end
            end
            OFS_FLIM: begin
               maxf_r  <= avs_writedata[15:0];
               mains_r <= avs_writedata[31:16];
            end
            OFS_MOTOR: begin
               rated_r <= avs_writedata[15:0];
               lossf_r <= avs_writedata[31:16];
            end
            OFS_AMPS: begin
               motor_a_r <= avs_writedata[15:0];
               drive_a_r <= avs_writedata[31:16];
            end
            default: begin
               if (avs_address >= OFS_ACC0 && avs_address < OFS_FLIM && avs_address[1:0] == 2'h0) begin
                  acc_r[avs_address[3:2] + 2'h3] <= avs_writedata[15:0];
                  dec_r[avs_address[3:2] + 2'h3] <= avs_writedata[31:16];
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Derived settings
   // ****************************************************************
   logic        run;
   logic        cmd_dir;
   logic        is_async;
   logic [1:0]  smode;
   logic [1:0]  tmode;
   logic [1:0]  rmode;
   logic [15:0] tgt_eff;
   logic        dir_r;
   logic [15:0] goal;
   logic        ramp_up;
   logic [31:0] t_ms;
   logic [15:0] trk_start;
   logic [31:0] amp_base;
   logic        ms_tick;
   logic [19:0] ms_div_r;
   logic [31:0] ph_ms_r;
   logic [31:0] brake_ms;
   logic [31:0] hold_ms;

   assign run      = ctrl_r[CTRL_RUN];
   assign cmd_dir  = ctrl_r[CTRL_DIR];
   assign is_async = ctrl_r[CTRL_ASYNC];
   assign smode    = mode_r[MODE_START +: 2];
   assign tmode    = mode_r[MODE_TRK +: 2];
   assign rmode    = mode_r[MODE_RAMP +: 2];
   assign tgt_eff  = (tgt_r > maxf_r) ? maxf_r : tgt_r;
   assign brake_ms = 32'(btime_r) * MS_PER_T;
   assign hold_ms  = 32'(hold_r) * MS_PER_T;

   // A reversal first heads to zero, then the other way.
   assign goal    = (cmd_dir != dir_r) ? 16'h0 : tgt_eff;
   assign ramp_up = goal > freq_r;
   // Terminal inputs pick one of four time sets.
   assign t_ms    = 32'(ramp_up ? acc_r[multi_function_inputs[1:0]] : dec_r[multi_function_inputs[1:0]]) * MS_PER_T;

   // Search starting point.
   always_comb begin
      case (tmode)
         TM_MAINS: trk_start = mains_r;
         TM_MAX:   trk_start = maxf_r;
         default:  trk_start = lossf_r;
      endcase
   end

   // Percentages refer to motor rating, or 80% of drive rating.
   assign amp_base = (32'(motor_a_r) * 32'h5 <= 32'(drive_a_r) * 32'h4) ? 32'(motor_a_r) :
                     mss_scale(32'(drive_a_r), 32'h4, 32'h5);
   // Brake and excite current scale with the percentage setting.
   assign dc_amp   = 16'(mss_scale(amp_base, 32'(bcur_r), 32'h64));

   assign ms_tick = ms_div_r == 20'(MS_CYC_P - 1);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ms_div_r <= 20'h0;
      end else begin
         ms_div_r <= ms_tick ? 20'h0 : ms_div_r + 20'h1;
      end
   end

   // ****************************************************************
   // Phase sequencing
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (run) begin
               if (tgt_eff < sfreq_r) begin
                  state_nxt = ST_STANDBY;
               end else if (smode == SM_TRACK) begin
                  state_nxt = ST_TRACK;
               end else if (smode == SM_DIRECT && btime_r != 16'h0) begin
                  state_nxt = ST_BRAKE;
               end else if (smode == SM_EXCITE && is_async && btime_r != 16'h0) begin
                  state_nxt = ST_EXCITE;
               end else begin
                  state_nxt = ST_HOLD;
               end
            end
         end
         ST_STANDBY: begin
            if (tgt_eff >= sfreq_r) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_BRAKE, ST_EXCITE: begin
            if (ph_ms_r >= brake_ms) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_TRACK: begin
            if (track_match) begin
               state_nxt = ST_RAMP;
            end else if (freq_r == 16'h0) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (ph_ms_r >= hold_ms) begin
               state_nxt = ST_RAMP;
            end
         end
         ST_RAMP:  state_nxt = ST_RAMP;
         default:  state_nxt = ST_IDLE;
      endcase
      if (!run) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************************
   // Ramp shaping
   // ****************************************************************
   logic [15:0] goal_r;
   logic [15:0] span_r;
   logic [31:0] racc_r;
   logic [31:0] seg_up;
   logic [31:0] band;
   logic [31:0] rem;
   logic [31:0] k_up;
   logic [31:0] k_dn;
   logic [31:0] k;
   logic        s_on;
   logic [31:0] add;
   logic        restart;

   // Dynamic shape drops to linear for long times or high targets.
   assign s_on = (rmode == RM_STATIC) ||
                 (rmode == RM_DYN && t_ms <= DYN_T_MAX * MS_PER_T && 32'(tgt_eff) <= 32'(rated_r) * DYN_F_MULT);
   // Dynamic reshapes on any goal change; static only once settled.
   assign restart = (state_r != ST_RAMP) || (freq_r == goal) || (rmode == RM_DYN && goal != goal_r);

   assign seg_up = mss_scale(t_ms, 32'(sst_r), PERMILLE);
   assign band   = mss_scale(32'(span_r), 32'(send_r), PERMILLE * 32'h2);
   assign rem    = 32'(mss_absdiff(goal, freq_r));

   // Slope rises over the start share and falls over the end share.
   always_comb begin
      k_up = (seg_up == 32'h0 || ph_ms_r >= seg_up) ? PERMILLE : mss_scale(ph_ms_r, PERMILLE, seg_up);
      k_dn = (band == 32'h0 || rem >= band) ? PERMILLE : mss_scale(rem, PERMILLE, band);
      k    = (k_up < k_dn) ? k_up : k_dn;
      if (k < K_MIN) begin
         k = K_MIN;
      end
      add = s_on ? mss_scale(32'(maxf_r), k, PERMILLE) : 32'(maxf_r);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         goal_r <= 16'h0;
         span_r <= 16'h0;
      end else begin
         goal_r <= goal;
         if (restart) begin
            span_r <= mss_absdiff(goal, freq_r);
         end
      end
   end

   // Phase time counter in milliseconds, cleared on each new phase.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_ms_r <= 32'h0;
      end else if (state_nxt != state_r || (state_r == ST_RAMP && restart)) begin
         ph_ms_r <= 32'h0;
      end else if (ms_tick) begin
         ph_ms_r <= ph_ms_r + 32'h1;
      end
   end

   // ****************************************************************
   // Output frequency and direction
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_r <= 16'h0;
         racc_r <= 32'h0;
         dir_r  <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               racc_r <= 32'h0;
               dir_r  <= cmd_dir;
               freq_r <= (state_nxt == ST_TRACK) ? trk_start : 16'h0;
            end
            ST_TRACK: begin
               if (track_match) begin
                  dir_r <= track_dir;
               end else if (ms_tick) begin
                  // Search descends faster for a larger rate.
                  freq_r <= (freq_r > 16'(trate_r)) ? freq_r - 16'(trate_r) : 16'h0;
               end
            end
            ST_HOLD: begin
               freq_r <= sfreq_r;
               racc_r <= 32'h0;
            end
            ST_RAMP: begin
               // Hold time never enters this accumulator.
               if (freq_r == goal) begin
                  racc_r <= 32'h0;
                  if (freq_r == 16'h0 && cmd_dir != dir_r) begin
                     dir_r <= cmd_dir;
                  end
               end else if (t_ms == 32'h0) begin
                  freq_r <= goal;
               end else if (ms_tick) begin
                  racc_r <= racc_r + add;
               end else if (racc_r >= t_ms) begin
                  racc_r <= racc_r - t_ms;
                  freq_r <= ramp_up ? freq_r + 16'h1 : freq_r - 16'h1;
               end
            end
            default: begin
               freq_r <= 16'h0;
               racc_r <= 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_r <= '0;
      end else begin
         drive_r.en     <= !(state_r inside {ST_IDLE, ST_STANDBY});
         drive_r.dir    <= dir_r;
         drive_r.dc_on  <= state_r inside {ST_BRAKE, ST_EXCITE};
         drive_r.excite <= state_r == ST_EXCITE;
         drive_r.hold   <= state_r == ST_HOLD;
         drive_r.freq   <= (state_r == ST_HOLD) ? sfreq_r : (state_r inside {ST_RAMP, ST_TRACK}) ? freq_r : 16'h0;
         drive_r.cur    <= (state_r inside {ST_BRAKE, ST_EXCITE}) ? dc_amp : 16'h0;
      end
   end

   assign drive = drive_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   property p_standby_zero;
      state_r == ST_STANDBY |=> !drive.en && drive.freq == 16'h0;
   endproperty
   a_standby_zero: assert property (p_standby_zero) else $error("Standby drives output.");

   property p_stop_abort;
      !run && state_r != ST_IDLE |=> state_r == ST_IDLE ##1 !drive.en;
   endproperty
   a_stop_abort: assert property (p_stop_abort) else $error("Stop did not abort.");

   property p_direct_nobrake;
      state_r == ST_IDLE && run && smode == SM_DIRECT && btime_r == 16'h0 && tgt_eff >= sfreq_r
         |=> state_r == ST_HOLD ##1 drive.freq == $past(sfreq_r);
   endproperty
   a_direct_nobrake: assert property (p_direct_nobrake) else $error("Direct start did not hold.");

   property p_direct_brake;
      state_r == ST_IDLE && run && smode == SM_DIRECT && btime_r != 16'h0 && tgt_eff >= sfreq_r
         |=> state_r == ST_BRAKE ##1 drive.dc_on && drive.cur == $past(dc_amp);
   endproperty
   a_direct_brake: assert property (p_direct_brake) else $error("Direct start did not brake.");

   property p_brake_only_direct;
      state_r == ST_BRAKE |-> smode == SM_DIRECT && btime_r != 16'h0;
   endproperty
   a_brake_only_direct: assert property (p_brake_only_direct) else $error("Braking outside direct mode.");

   property p_excite_async;
      state_r == ST_EXCITE |-> is_async && smode == SM_EXCITE && btime_r != 16'h0;
   endproperty
   a_excite_async: assert property (p_excite_async) else $error("Excitation without asynchronous motor.");

   property p_hold_freq;
      state_r == ST_HOLD && run |=> drive.freq == $past(sfreq_r) && drive.hold;
   endproperty
   a_hold_freq: assert property (p_hold_freq) else $error("Hold frequency wrong.");

   property p_excite_end;
      state_r == ST_EXCITE && run && ph_ms_r >= brake_ms |=> state_r == ST_HOLD;
   endproperty
   a_excite_end: assert property (p_excite_end) else $error("Excitation overran.");

   property p_reverse_nohold;
      state_r == ST_RAMP && run && freq_r == 16'h0 && cmd_dir != dir_r |=> state_r == ST_RAMP && dir_r == $past(cmd_dir);
   endproperty
   a_reverse_nohold: assert property (p_reverse_nohold) else $error("Reversal entered hold.");

endmodule

//--- inc/mss_pkg.sv
package mss_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int          CLK_NS     = 40;
   localparam int          MS_NS      = 1000000;
   localparam int          MS_CYC     = MS_NS / CLK_NS;
   localparam int          MS_PER_T   = 100;
   localparam logic [31:0] DYN_T_MAX  = 32'h0000_03e8;
   localparam logic [31:0] DYN_F_MULT = 32'h0000_0006;
   localparam logic [31:0] PERMILLE   = 32'h0000_03e8;
   localparam logic [31:0] K_MIN      = 32'h0000_0014;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MODE   = 8'h04;
   localparam logic [7:0] OFS_TRATE  = 8'h08;
   localparam logic [7:0] OFS_SFREQ  = 8'h0c;
   localparam logic [7:0] OFS_HOLD   = 8'h10;
   localparam logic [7:0] OFS_BCUR   = 8'h14;
   localparam logic [7:0] OFS_BTIME  = 8'h18;
   localparam logic [7:0] OFS_SCURVE = 8'h1c;
   localparam logic [7:0] OFS_TARGET = 8'h20;
   localparam logic [7:0] OFS_ACC0   = 8'h24;
   localparam logic [7:0] OFS_FLIM   = 8'h34;
   localparam logic [7:0] OFS_MOTOR  = 8'h38;
   localparam logic [7:0] OFS_AMPS   = 8'h3c;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam logic [7:0] OFS_OUTCUR = 8'h44;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_RUN   = 0;
   localparam int CTRL_DIR   = 1;
   localparam int CTRL_ASYNC = 2;
   localparam int MODE_START = 0;
   localparam int MODE_TRK   = 2;
   localparam int MODE_RAMP  = 4;
   localparam int HI_HALF    = 16;

   // ****************************************************************
   // Mode encodings
   // ****************************************************************
   localparam logic [1:0] SM_DIRECT = 2'h0;
   localparam logic [1:0] SM_TRACK  = 2'h1;
   localparam logic [1:0] SM_EXCITE = 2'h2;
   localparam logic [1:0] TM_LOSS   = 2'h0;
   localparam logic [1:0] TM_MAINS  = 2'h1;
   localparam logic [1:0] TM_MAX    = 2'h2;
   localparam logic [1:0] RM_LIN    = 2'h0;
   localparam logic [1:0] RM_STATIC = 2'h1;
   localparam logic [1:0] RM_DYN    = 2'h2;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [6:0]  RST_TRATE  = 7'h14;
   localparam logic [15:0] RST_SFREQ  = 16'h0000;
   localparam logic [15:0] RST_HOLD   = 16'h0000;
   localparam logic [6:0]  RST_BCUR   = 7'h00;
   localparam logic [15:0] RST_BTIME  = 16'h0000;
   localparam logic [15:0] RST_SRATIO = 16'h012c;
   localparam logic [15:0] RST_ACC    = 16'h0064;
   localparam logic [15:0] RST_FREQ   = 16'h1388;
   localparam logic [15:0] RST_AMPS   = 16'h0064;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_STANDBY = 7'h02,
      ST_BRAKE   = 7'h04,
      ST_EXCITE  = 7'h08,
      ST_TRACK   = 7'h10,
      ST_HOLD    = 7'h20,
      ST_RAMP    = 7'h40
   } mss_state_t;

   typedef struct packed {
      logic        en;
      logic        dir;
      logic        dc_on;
      logic        excite;
      logic        hold;
      logic [15:0] freq;
      logic [15:0] cur;
   } mss_drive_t;

   function automatic logic [31:0] mss_scale(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
      logic [63:0] p;
      p = {32'h0, a} * {32'h0, b};
      if (c == 32'h0) begin
         mss_scale = 32'h0;
      end else begin
         mss_scale = 32'(p / {32'h0, c});
      end
   endfunction

   function automatic logic [15:0] mss_absdiff(input logic [15:0] a, input logic [15:0] b);
      mss_absdiff = (a > b) ? (a - b) : (b - a);
   endfunction

endpackage

//--- test/mss_stage_model.sv
`timescale 1ns/1ps
module mss_stage_model
   import mss_pkg::*;
#(
   parameter logic [15:0] MATCH_F = 16'h0fa0
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire mss_drive_t drive,
   output logic            track_match,
   output logic            track_dir
);
   // The motor spins in reverse and reports a match once the search falls to MATCH_F or below.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         track_match <= 1'b0;
         track_dir   <= 1'b0;
      end else begin
         track_match <= drive.en && (drive.freq <= MATCH_F);
         track_dir   <= 1'b1;
      end
   end
endmodule

//--- test/test_motor_start_sequencer.sv
`timescale 1ns/1ps
module test_motor_start_sequencer;
   import mss_pkg::*;
   logic        sys_clk, rst_n, rd_en, wr_en, wreq, match, tdir;
   logic [7:0]  addr;
   logic [8:0]  mfi;
   logic [31:0] wdat, rdat, v;
   mss_drive_t  drive;
   int          n_fail, comparisons;
   mss_sequencer #(.MS_CYC_P(10)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .multi_function_inputs(mfi),
      .track_match(match), .track_dir(tdir), .drive(drive));
   mss_stage_model u_stage (.sys_clk(sys_clk), .rst_n(rst_n), .drive(drive),
      .track_match(match), .track_dir(tdir));
   task wrap_up;
      $display("checks %0d fails %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task ack;
      int i;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (wreq !== 1'b0 && i < 20);
      if (wreq !== 1'b0) begin
         chk({31'h0, wreq}, 32'h0);
         wrap_up;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdat <= d;
      wr_en <= 1'b1;
      ack;
      wr_en <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      ack;
      d = rdat;
      rd_en <= 1'b0;
   endtask
   task aw(input logic [6:0] s);
      int i;
      i = 0;
      v = 32'h0;
      while (v[6:0] !== s && i < 4000) begin
         rd(OFS_STATUS, v);
         i++;
      end
      chk({25'h0, v[6:0]}, {25'h0, s});
      if (v[6:0] !== s) wrap_up;
   endtask
   task t_reset;
      chk({27'h0, drive[36:32]}, 32'h0);
      rd(OFS_TRATE, v);
      chk(v, 32'h0000_0014);
      rd(OFS_SCURVE, v);
      chk(v, 32'h012c_012c);
      rd(8'h80, v);
      chk(v, 32'h0);
   endtask
   task t_stop;
      wr(OFS_CTRL, 32'h0);
      repeat (3) @(negedge sys_clk);
      chk({31'h0, drive.en}, 32'h0);
   endtask
   task t_standby;
      wr(OFS_SFREQ, 32'h0000_01f4);
      wr(OFS_TARGET, 32'h0000_0064);
      wr(OFS_CTRL, 32'h1);
      aw(7'h02);
      chk({15'h0, drive.en, drive.freq}, 32'h0);
      t_stop;
   endtask
   task t_brake;
      wr(OFS_TARGET, 32'h0000_03e8);
      wr(OFS_BTIME, 32'h1);
      wr(OFS_BCUR, 32'h0000_0032);
      wr(OFS_HOLD, 32'h1);
      wr(OFS_CTRL, 32'h1);
      aw(7'h04);
      chk({15'h0, drive.dc_on, drive.cur}, 32'h0001_0028);
      aw(7'h20);
      chk({15'h0, drive.hold, drive.freq}, 32'h0001_01f4);
      aw(7'h40);
      t_stop;
   endtask
   task t_track;
      wr(OFS_MODE, 32'h0000_0009);
      wr(OFS_CTRL, 32'h1);
      aw(7'h10);
      aw(7'h40);
      chk({31'h0, drive.dir}, 32'h1);
      t_stop;
   endtask
   task t_excite;
      wr(OFS_MODE, 32'h0000_0002);
      wr(OFS_CTRL, 32'h0000_0005);
      aw(7'h08);
      chk({14'h0, drive.dc_on, drive.excite, drive.cur}, 32'h0003_0028);
      aw(7'h20);
      t_stop;
   endtask
   task t_jump;
      mfi <= 9'h001;
      wr(OFS_ACC0 + 8'h4, 32'h0);
      wr(OFS_MODE, 32'h0);
      wr(OFS_BTIME, 32'h0);
      wr(OFS_HOLD, 32'h0);
      wr(OFS_CTRL, 32'h1);
      aw(7'h40);
      rd(OFS_STATUS, v);
      chk(v, 32'h03e8_0040);
      wr(OFS_CTRL, 32'h3);
      repeat (4) @(posedge sys_clk);
      rd(OFS_STATUS, v);
      chk(v, 32'h03e8_0040);
      chk({31'h0, drive.dir}, 32'h1);
      mfi <= 9'h000;
      t_stop;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      {rst_n, rd_en, wr_en, addr, wdat, mfi, n_fail, comparisons} = '0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset;
      t_standby;
      t_brake;
      t_track;
      t_excite;
      t_jump;
      wrap_up;
   end
endmodule
